// ==== core/codec_cmd_pkg.sv ====
package codec_cmd_pkg;
	// ****************************************************************
	// command word layout
	// ****************************************************************
	localparam int         WORD_BITS      = 16;
	localparam int         CTRL_HI_BIT    = 15;
	localparam int         CTRL_LO_BIT    = 14;
	localparam int         RW_BIT         = 13;
	localparam int         ADDR_MSB       = 12;
	localparam int         ADDR_LSB       = 8;
	localparam int         DATA_MSB       = 7;
	localparam int         PRI_CTRL_HI    = 1;
	localparam int         PRI_CTRL_LO    = 0;
	// position of read/write bit and address once the upper byte is in
	localparam int         HEAD_RW_BIT    = 5;
	localparam int         HEAD_ADDR_MSB  = 4;
	localparam logic [4:0] LAST_EDGE_CNT  = 5'h0f;
	localparam logic [4:0] HEAD_EDGE_CNT  = 5'h07;
	localparam logic [4:0] FIRST_CNT      = 5'h01;

	// ****************************************************************
	// register addresses and reset values
	// ****************************************************************
	localparam logic [4:0] ADDR_NO_OPERATION   = 5'h00;
	localparam logic [4:0] ADDR_FILTER_DIV     = 5'h01;
	localparam logic [4:0] ADDR_CONVERSION_DIV = 5'h02;
	localparam logic [4:0] ADDR_PHASE_OFFSET   = 5'h03;
	localparam logic [4:0] ADDR_GAIN_SELECT    = 5'h04;
	localparam logic [7:0] RST_FILTER_DIV      = 8'h12;
	localparam logic [7:0] RST_CONVERSION_DIV  = 8'h12;
	localparam logic [7:0] RST_PHASE_OFFSET    = 8'h00;
	localparam logic [7:0] RST_GAIN_SELECT     = 8'h05;
	localparam logic [7:0] GAIN_USED_MASK      = 8'h3f;
	localparam int         MON_GAIN_MSB        = 5;
	localparam int         MON_GAIN_LSB        = 4;
	localparam int         IN_GAIN_MSB         = 3;
	localparam int         IN_GAIN_LSB         = 2;
	localparam int         OUT_GAIN_MSB        = 1;
	localparam int         OUT_GAIN_LSB        = 0;

	// ****************************************************************
	// control bit codes
	// ****************************************************************
	localparam logic [1:0] CTRL_NONE     = 2'h0;
	localparam logic [1:0] CTRL_LATER    = 2'h1;
	localparam logic [1:0] CTRL_EARLIER  = 2'h2;
	localparam logic [1:0] CTRL_HARDWARE = 2'h3;

	typedef enum logic [1:0] {
		FRAME_IDLE,
		FRAME_PRIMARY,
		FRAME_SECONDARY
	} frame_state_type;
endpackage

// ==== core/codec_secondary_cmd_regs.sv ====
// How it works
// - write command: bits 12..8 address a register, bits 7..0 are stored there (only bits 5..0 at address 4)
// - during a write command the outgoing word is all zeros
// - read command reads the addressed register, incoming data byte ignored
// - phase-shift control bits still act during a read command
// - read data goes out in the low byte, upper byte zero
// - address zero changes no register
// - reading address zero returns a zero byte
// - address 1 holds the filter clock divisor, bit 7 most significant
// - filter clock is master clock divided by twice the divisor
// - filter clock divisor resets to eighteen
// - address 2 divides the filter clock into the conversion rate
// - conversion divisor resets to eighteen
// - address 3 holds signed sample-phase offset in master clock periods
// - sample-phase offset resets to zero
// - gain bits 5..4 select monitor gain
// - gain bits 3..2 select input gain, reset code 01
// - gain bits 1..0 select output gain
// - monitor gain resets to squelch, output gain to 0 dB
// - command takes effect on the sixteenth falling shift clock edge
// - a read leaves register contents unchanged
// - top two command bits select phase shift; code 00 ignores the pins and no secondary request is raised
module codec_secondary_cmd_regs
	import codec_cmd_pkg::*;
(
	input  wire logic       clock_in,
	input  wire logic       rst_b_in,
	input  wire logic       enable_in,
	input  wire logic       shift_clock_in,
	input  wire logic       frame_sync_in,
	input  wire logic       secondary_frame_in,
	input  wire logic       serial_data_in,
	input  wire logic [1:0] hardware_request_in,
	output logic            serial_data_out,
	output logic            phase_earlier_out,
	output logic            phase_later_out,
	output logic            secondary_request_out,
	output logic            filter_clock_tick_out,
	output logic            conversion_tick_out,
	output logic [7:0]      filter_clock_divisor_out,
	output logic [7:0]      conversion_rate_divisor_out,
	output logic [7:0]      sample_phase_offset_out,
	output logic [1:0]      monitor_gain_out,
	output logic [1:0]      input_gain_out,
	output logic [1:0]      output_gain_out
);
	// ****************************************************************
	// decoding helpers
	// ****************************************************************
	// returns {earlier, later}; zero code consults the pins only in primary words
	function automatic logic [1:0] phase_decode(input logic [1:0] ctrl,
	                                            input logic [1:0] pins,
	                                            input logic       primary);
		logic use_pins;
		use_pins = (ctrl == CTRL_HARDWARE) || (primary && ctrl == CTRL_NONE);
		if (use_pins) begin
			phase_decode = (pins == CTRL_EARLIER || pins == CTRL_LATER) ? pins : 2'h0;
		end else if (ctrl == CTRL_EARLIER || ctrl == CTRL_LATER) begin
			phase_decode = ctrl;
		end else begin
			phase_decode = 2'h0;
		end
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	frame_state_type state_q;
	frame_state_type state_d;
	logic            shift_clock_q;
	logic [4:0]      bit_cnt_q;
	logic [15:0]     shift_q;
	logic [7:0]      out_byte_q;
	logic            dout_q;
	logic            read_active_q;
	logic [7:0]      filter_div_q;
	logic [7:0]      conversion_div_q;
	logic [7:0]      phase_offset_q;
	logic [7:0]      gain_q;
	logic [8:0]      filter_cnt_q;
	logic [7:0]      conversion_cnt_q;
	logic            filter_tick_q;
	logic            conversion_tick_q;
	logic            earlier_q;
	logic            later_q;
	logic            request_q;

	// ****************************************************************
	// serial framing
	// ****************************************************************
	wire        shift_fall  = enable_in && shift_clock_q && !shift_clock_in;
	wire        frame_start = shift_fall && state_q == FRAME_IDLE && frame_sync_in;
	wire        in_frame    = shift_fall && state_q != FRAME_IDLE;
	wire [15:0] word_next   = {shift_q[WORD_BITS-2:0], serial_data_in};
	wire        word_done   = in_frame && bit_cnt_q == LAST_EDGE_CNT;
	wire        head_done   = in_frame && bit_cnt_q == HEAD_EDGE_CNT;
	wire        is_second   = state_q == FRAME_SECONDARY;
	wire        head_rw     = word_next[HEAD_RW_BIT];
	wire [4:0]  head_addr   = word_next[HEAD_ADDR_MSB:0];
	wire        cmd_rw      = word_next[RW_BIT];
	wire [4:0]  cmd_addr    = word_next[ADDR_MSB:ADDR_LSB];
	wire [7:0]  cmd_data    = word_next[DATA_MSB:0];
	wire        sec_write   = word_done && is_second && !cmd_rw;
	wire        wr_filter   = sec_write && cmd_addr == ADDR_FILTER_DIV;
	wire        wr_conv     = sec_write && cmd_addr == ADDR_CONVERSION_DIV;
	wire        wr_phase    = sec_write && cmd_addr == ADDR_PHASE_OFFSET;
	wire        wr_gain     = sec_write && cmd_addr == ADDR_GAIN_SELECT;
	wire [1:0]  ctrl_bits   = is_second ? word_next[CTRL_HI_BIT:CTRL_LO_BIT]
	                                    : word_next[PRI_CTRL_HI:PRI_CTRL_LO];
	wire [1:0]  phase_req   = phase_decode(ctrl_bits, hardware_request_in,
	                                       !is_second);
	wire        sec_request = !is_second && (ctrl_bits == CTRL_HARDWARE ||
	                                         hardware_request_in == CTRL_HARDWARE);

	// address zero and unimplemented addresses read as zero
	wire [7:0]  read_byte   = (head_addr == ADDR_FILTER_DIV)     ? filter_div_q     :
	                          (head_addr == ADDR_CONVERSION_DIV) ? conversion_div_q :
	                          (head_addr == ADDR_PHASE_OFFSET)   ? phase_offset_q   :
	                          (head_addr == ADDR_GAIN_SELECT)    ? gain_q           :
	                          8'h00;
	wire        do_read     = head_done && is_second && head_rw;
	wire [7:0]  load_byte   = do_read ? read_byte : 8'h00;

	always_comb begin
		state_d = state_q;
		case (state_q)
			FRAME_IDLE: begin
				if (frame_start) begin
					state_d = secondary_frame_in ? FRAME_SECONDARY : FRAME_PRIMARY;
				end
			end
			FRAME_PRIMARY,
			FRAME_SECONDARY: begin
				if (word_done) begin
					state_d = FRAME_IDLE;
				end
			end
			default: begin
				state_d = FRAME_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q       <= FRAME_IDLE;
			shift_clock_q <= 1'b0;
			bit_cnt_q     <= 5'h00;
			shift_q       <= 16'h0000;
		end else if (enable_in) begin
			state_q       <= state_d;
			shift_clock_q <= shift_clock_in;
			if (frame_start) begin
				bit_cnt_q <= FIRST_CNT;
				shift_q   <= word_next;
			end else if (in_frame) begin
				bit_cnt_q <= word_done ? 5'h00 : bit_cnt_q + FIRST_CNT;
				shift_q   <= word_next;
			end
		end
	end

	// ****************************************************************
	// outgoing word: zeros, then the read byte msb first
	// ****************************************************************
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			out_byte_q    <= 8'h00;
			dout_q        <= 1'b0;
			read_active_q <= 1'b0;
		end else if (head_done) begin
			dout_q        <= load_byte[DATA_MSB];
			out_byte_q    <= {load_byte[DATA_MSB-1:0], 1'b0};
			read_active_q <= do_read;
		end else if (word_done || frame_start) begin
			dout_q        <= 1'b0;
			out_byte_q    <= 8'h00;
			read_active_q <= 1'b0;
		end else if (in_frame) begin
			dout_q        <= out_byte_q[DATA_MSB];
			out_byte_q    <= {out_byte_q[DATA_MSB-1:0], 1'b0};
		end
	end

	// ****************************************************************
	// configuration registers
	// ****************************************************************
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			filter_div_q     <= RST_FILTER_DIV;
			conversion_div_q <= RST_CONVERSION_DIV;
			phase_offset_q   <= RST_PHASE_OFFSET;
			gain_q           <= RST_GAIN_SELECT;
		end else begin
			if (wr_filter) begin
				filter_div_q <= cmd_data;
			end
			if (wr_conv) begin
				conversion_div_q <= cmd_data;
			end
			if (wr_phase) begin
				phase_offset_q <= cmd_data;
			end
			if (wr_gain) begin
				gain_q <= cmd_data & GAIN_USED_MASK;
			end
		end
	end

	// ****************************************************************
	// control bit strobes
	// ****************************************************************
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			earlier_q <= 1'b0;
			later_q   <= 1'b0;
			request_q <= 1'b0;
		end else if (enable_in) begin
			earlier_q <= word_done && phase_req[1];
			later_q   <= word_done && phase_req[0];
			request_q <= word_done && sec_request;
		end
	end

	// ****************************************************************
	// filter clock and conversion rate dividers
	// ****************************************************************
	wire [8:0] filter_period = {filter_div_q, 1'b0};
	wire [8:0] filter_cnt_nx = filter_cnt_q + 9'h001;
	wire       filter_wrap   = filter_cnt_nx >= filter_period;
	wire [7:0] conv_cnt_nx   = conversion_cnt_q + 8'h01;
	wire       conv_wrap     = conv_cnt_nx >= conversion_div_q;

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			filter_cnt_q      <= 9'h000;
			conversion_cnt_q  <= 8'h00;
			filter_tick_q     <= 1'b0;
			conversion_tick_q <= 1'b0;
		end else if (enable_in) begin
			filter_cnt_q      <= filter_wrap ? 9'h000 : filter_cnt_nx;
			filter_tick_q     <= filter_wrap;
			conversion_tick_q <= filter_wrap && conv_wrap;
			if (filter_wrap) begin
				conversion_cnt_q <= conv_wrap ? 8'h00 : conv_cnt_nx;
			end
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign serial_data_out             = dout_q;
	assign phase_earlier_out           = earlier_q;
	assign phase_later_out             = later_q;
	assign secondary_request_out       = request_q;
	assign filter_clock_tick_out       = filter_tick_q;
	assign conversion_tick_out         = conversion_tick_q;
	assign filter_clock_divisor_out    = filter_div_q;
	assign conversion_rate_divisor_out = conversion_div_q;
	assign sample_phase_offset_out     = phase_offset_q;
	assign monitor_gain_out            = gain_q[MON_GAIN_MSB:MON_GAIN_LSB];
	assign input_gain_out              = gain_q[IN_GAIN_MSB:IN_GAIN_LSB];
	assign output_gain_out             = gain_q[OUT_GAIN_MSB:OUT_GAIN_LSB];

	// ****************************************************************
	// assertions
	// ****************************************************************
	property p_reset_defaults;
		@(posedge clock_in) disable iff (!rst_b_in)
		!$past(rst_b_in) |-> (filter_div_q == RST_FILTER_DIV &&
		                      conversion_div_q == RST_CONVERSION_DIV &&
		                      phase_offset_q == RST_PHASE_OFFSET && gain_q == RST_GAIN_SELECT);
	endproperty
	a_reset_defaults: assert property (p_reset_defaults)
		else $error("registers not at defaults after reset");

	property p_write_filter;
		@(posedge clock_in) disable iff (!rst_b_in)
		wr_filter |=> filter_div_q == $past(word_next[DATA_MSB:0]);
	endproperty
	a_write_filter: assert property (p_write_filter)
		else $error("filter divisor write lost");

	property p_read_keeps;
		@(posedge clock_in) disable iff (!rst_b_in)
		(word_done && is_second && cmd_rw) |=>
			$stable(filter_div_q) && $stable(conversion_div_q) &&
			$stable(phase_offset_q) && $stable(gain_q);
	endproperty
	a_read_keeps: assert property (p_read_keeps)
		else $error("read changed a register");

	property p_noop_keeps;
		@(posedge clock_in) disable iff (!rst_b_in)
		(word_done && cmd_addr == 5'h00) |=>
			$stable(filter_div_q) && $stable(conversion_div_q) &&
			$stable(phase_offset_q) && $stable(gain_q);
	endproperty
	a_noop_keeps: assert property (p_noop_keeps)
		else $error("no-op address changed a register");

	property p_write_quiet;
		@(posedge clock_in) disable iff (!rst_b_in)
		dout_q |-> read_active_q;
	endproperty
	a_write_quiet: assert property (p_write_quiet)
		else $error("data driven outside read byte");

	property p_noop_read_zero;
		@(posedge clock_in) disable iff (!rst_b_in)
		(do_read && head_addr == ADDR_NO_OPERATION) |=> (!dout_q && out_byte_q == 8'h00);
	endproperty
	a_noop_read_zero: assert property (p_noop_read_zero)
		else $error("no-op read not zero");

	property p_gain_top_zero;
		@(posedge clock_in) disable iff (!rst_b_in)
		wr_gain |=> (gain_q & ~GAIN_USED_MASK) == 8'h00 &&
			gain_q[MON_GAIN_MSB:0] == $past(word_next[MON_GAIN_MSB:0]);
	endproperty
	a_gain_top_zero: assert property (p_gain_top_zero)
		else $error("gain write wrong");

	property p_change_on_last_edge;
		@(posedge clock_in) disable iff (!rst_b_in)
		$changed(filter_div_q) |-> $past(word_done) && $past(is_second);
	endproperty
	a_change_on_last_edge: assert property (p_change_on_last_edge)
		else $error("register changed outside sixteenth edge");

	property p_read_phase;
		@(posedge clock_in) disable iff (!rst_b_in)
		(word_done && is_second && cmd_rw &&
		 word_next[CTRL_HI_BIT:CTRL_LO_BIT] == CTRL_EARLIER) |=>
			phase_earlier_out && !phase_later_out;
	endproperty
	a_read_phase: assert property (p_read_phase)
		else $error("phase request lost in read");

	property p_filter_period;
		@(posedge clock_in) disable iff (!rst_b_in)
		(enable_in && filter_div_q != 8'h00 && filter_cnt_q < filter_period) |->
			filter_wrap == (filter_cnt_q == filter_period - 9'h001);
	endproperty
	a_filter_period: assert property (p_filter_period)
		else $error("filter tick period wrong");
endmodule

// ==== verification/host_serial_model.sv ====
module host_serial_model
	import codec_cmd_pkg::*;
(
	input  wire logic       clock_in,
	input  wire logic       serial_data_in,
	output logic            shift_clock_out,
	output logic            frame_sync_out,
	output logic            secondary_frame_out,
	output logic            serial_data_out,
	output logic [1:0]      hardware_request_out
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		shift_clock_out      = 1'b0;
		frame_sync_out       = 1'b0;
		secondary_frame_out  = 1'b0;
		serial_data_out      = 1'b0;
		hardware_request_out = 2'h0;
	end

	// ****************************************************************
	// one word, msb first; shift clock stands low between words
	// ****************************************************************
	task automatic send_word(input logic [15:0] word, input logic sec, input logic [1:0] pins,
			input int half, output logic [15:0] rx);
		int i;
		int j;
		rx = 16'h0000;
		for (i = WORD_BITS - 1; i >= 0; i--) begin
			@(posedge clock_in);
			shift_clock_out      <= 1'b1;
			serial_data_out      <= word[i];
			frame_sync_out       <= (i == WORD_BITS - 1);
			secondary_frame_out  <= sec;
			hardware_request_out <= pins;
			for (j = 1; j < half; j++) @(posedge clock_in);
			@(posedge clock_in);
			shift_clock_out <= 1'b0;
			// device bit is taken at our falling edge
			rx = {rx[14:0], serial_data_in};
			for (j = 1; j < half; j++) @(posedge clock_in);
		end
		@(posedge clock_in);
		frame_sync_out  <= 1'b0;
		// released data line shows no stale value
		serial_data_out <= ~serial_data_out;
	endtask
endmodule

// ==== verification/test_codec_secondary_cmd_regs.sv ====
module test_codec_secondary_cmd_regs
	import codec_cmd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic       clock_in;
	logic       rst_b_in;
	logic       enable_in;
	logic       shift_clock;
	logic       frame_sync;
	logic       secondary_frame;
	logic       serial_in;
	logic       serial_out;
	logic [1:0] hw_request;
	logic       early;
	logic       late;
	logic       sec_req;
	logic       ftick;
	logic       ctick;
	logic [7:0] fdiv;
	logic [7:0] cdiv;
	logic [7:0] phase;
	logic [1:0] mon_gain;
	logic [1:0] in_gain;
	logic [1:0] out_gain;
	logic [7:0] exp_reg [1:4];
	logic [15:0] rx;
	int         err_count;
	int         checked;
	int         n_early;
	int         n_late;
	int         n_req;
	int         n_ftick;

	host_serial_model host (
		.clock_in            (clock_in),
		.serial_data_in      (serial_out),
		.shift_clock_out     (shift_clock),
		.frame_sync_out      (frame_sync),
		.secondary_frame_out (secondary_frame),
		.serial_data_out     (serial_in),
		.hardware_request_out(hw_request)
	);

	codec_secondary_cmd_regs DUT (
		.clock_in                   (clock_in),
		.rst_b_in                   (rst_b_in),
		.enable_in                  (enable_in),
		.shift_clock_in             (shift_clock),
		.frame_sync_in              (frame_sync),
		.secondary_frame_in         (secondary_frame),
		.serial_data_in             (serial_in),
		.hardware_request_in        (hw_request),
		.serial_data_out            (serial_out),
		.phase_earlier_out          (early),
		.phase_later_out            (late),
		.secondary_request_out      (sec_req),
		.filter_clock_tick_out      (ftick),
		.conversion_tick_out        (ctick),
		.filter_clock_divisor_out   (fdiv),
		.conversion_rate_divisor_out(cdiv),
		.sample_phase_offset_out    (phase),
		.monitor_gain_out           (mon_gain),
		.input_gain_out             (in_gain),
		.output_gain_out            (out_gain)
	);

	initial begin
		clock_in = 1'b0;
		forever #4 clock_in = ~clock_in;
	end

	always @(posedge clock_in) begin
		if (early === 1'b1) n_early++;
		if (late === 1'b1) n_late++;
		if (sec_req === 1'b1) n_req++;
		if (ftick === 1'b1) n_ftick++;
	end

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic xfer(input logic [1:0] ctrl, input logic rw, input logic [4:0] addr,
			input logic [7:0] data, input logic [1:0] pins);
		n_early = 0;
		n_late  = 0;
		n_req   = 0;
		host.send_word({ctrl, rw, addr, data}, 1'b1, pins, 2, rx);
		repeat (3) @(posedge clock_in);
	endtask

	task automatic check_all();
		chk("filter divisor", {8'h00, exp_reg[1]}, {8'h00, fdiv});
		chk("conversion divisor", {8'h00, exp_reg[2]}, {8'h00, cdiv});
		chk("phase offset", {8'h00, exp_reg[3]}, {8'h00, phase});
		chk("monitor gain", 16'(exp_reg[4][MON_GAIN_MSB:MON_GAIN_LSB]), 16'(mon_gain));
		chk("input gain", 16'(exp_reg[4][IN_GAIN_MSB:IN_GAIN_LSB]), 16'(in_gain));
		chk("output gain", 16'(exp_reg[4][OUT_GAIN_MSB:OUT_GAIN_LSB]), 16'(out_gain));
	endtask

	task automatic read_back();
		for (int a = 1; a <= 4; a++) begin
			xfer(2'h0, 1'b1, 5'(a), 8'ha5, 2'h0);
			chk("read word", {8'h00, exp_reg[a]}, rx);
		end
	endtask

	task automatic gap_check(input string what, input int expect_gap, input bit conv);
		int n;
		int k;
		int mark;
		k = 0;
		mark = 0;
		for (n = 0; n < 3000 && k < 3; n++) begin
			@(posedge clock_in);
			if ((conv ? ctick : ftick) === 1'b1) begin
				k++;
				if (k == 2) mark = n;
			end
		end
		if (k < 3) begin
			err_count++;
			$display("unexpected missing ticks on %s", what);
			close_out();
		end else begin
			chk(what, 16'(expect_gap), 16'(n - 1 - mark));
		end
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_reset();
		@(posedge clock_in);
		rst_b_in <= 1'b0;
		repeat (5) @(posedge clock_in);
		rst_b_in <= 1'b1;
		repeat (2) @(posedge clock_in);
		exp_reg[1] = RST_FILTER_DIV;
		exp_reg[2] = RST_CONVERSION_DIV;
		exp_reg[3] = RST_PHASE_OFFSET;
		exp_reg[4] = RST_GAIN_SELECT;
		check_all();
		read_back();
		check_all();
		$display("test reset done");
	endtask

	task automatic t_write();
		logic [7:0] vals [1:4];
		vals = '{8'h02, 8'h03, 8'h80, 8'hff};
		for (int a = 1; a <= 4; a++) begin
			xfer(2'h0, 1'b0, 5'(a), vals[a], 2'h0);
			chk("write word out", 16'h0000, rx);
			exp_reg[a] = (a == 4) ? (vals[a] & GAIN_USED_MASK) : vals[a];
			check_all();
		end
		read_back();
		check_all();
		for (int c = 0; c < 4; c++) begin
			exp_reg[4] = {2'h0, 2'(c), 2'(c), 2'(c)};
			xfer(2'h0, 1'b0, ADDR_GAIN_SELECT, exp_reg[4], 2'h0);
			check_all();
		end
		$display("test write done");
	endtask

	task automatic t_noop();
		xfer(2'h0, 1'b0, ADDR_NO_OPERATION, 8'hff, 2'h0);
		check_all();
		xfer(2'h0, 1'b1, ADDR_NO_OPERATION, 8'hff, 2'h0);
		chk("no-op read", 16'h0000, rx);
		xfer(2'h0, 1'b1, 5'h05, 8'h00, 2'h0);
		chk("unused read", 16'h0000, rx);
		$display("test no-op done");
	endtask

	task automatic t_phase();
		logic [5:0] tbl [0:5];
		tbl = '{6'h0c, 6'h11, 6'h22, 6'h3a, 6'h35, 6'h3c};
		for (int i = 0; i < 6; i++) begin
			xfer(tbl[i][5:4], 1'b1, ADDR_FILTER_DIV, 8'h00, tbl[i][3:2]);
			chk("earlier pulses", 16'(tbl[i][1]), 16'(n_early));
			chk("later pulses", 16'(tbl[i][0]), 16'(n_late));
			chk("request pulses", 16'h0000, 16'(n_req));
		end
		n_req = 0;
		host.send_word(16'h0003, 1'b0, 2'h0, 5, rx);
		repeat (3) @(posedge clock_in);
		chk("primary request", 16'h0001, 16'(n_req));
		n_early = 0;
		host.send_word(16'h0000, 1'b0, 2'h2, 2, rx);
		repeat (3) @(posedge clock_in);
		chk("primary pin earlier", 16'h0001, 16'(n_early));
		check_all();
		$display("test phase done");
	endtask

	task automatic t_divider();
		gap_check("filter tick gap", 2 * exp_reg[1], 1'b0);
		gap_check("conversion tick gap", 2 * exp_reg[1] * exp_reg[2], 1'b1);
		@(posedge clock_in);
		enable_in <= 1'b0;
		@(posedge clock_in);
		n_ftick = 0;
		repeat (20) @(posedge clock_in);
		chk("ticks while frozen", 16'h0000, 16'(n_ftick));
		enable_in <= 1'b1;
		$display("test divider done");
	endtask

	initial begin
		err_count = 0;
		checked   = 0;
		rst_b_in  = 1'b0;
		enable_in = 1'b1;
		repeat (5) @(posedge clock_in);
		rst_b_in <= 1'b1;
		t_reset();
		t_write();
		t_noop();
		t_phase();
		t_divider();
		t_reset();
		close_out();
	end
endmodule
